// ===== hdl/rlc_pkg.sv
/*
 constants and carrier types for the reference regulator state control register.
 assumes an spi register file in front that delivers decoded byte writes and reads on mclk.
*/
// Behaviour
// - live field: 4 off, 5 low power, 6 or 7 active; 0-3 reserved.
// - standby exit pin assertion copies exit field into live field.
// - exit field codes 0-3 leave live field unchanged on standby exit.
// - 8-bit register at 0x3F, read/write, resets to 0x24.
// - this regulator and its sibling have separate, independent control registers.
// - output actively discharged whenever this regulator is off.
// - combo supply acts as regulator at 1.8 V, as switch at 3.3 V.
package rlc_pkg;
   localparam logic [7:0] REF_LDO_CTRL_ADDR = 8'h3F;
   localparam logic [7:0] SIBLING_CTRL_ADDR = 8'h40;
   localparam logic [7:0] REF_LDO_CTRL_RST = 8'h24;
   localparam logic [7:0] SIBLING_CTRL_RST = 8'h3C;
   localparam int LIVE_LSB = 0;
   localparam int EXIT_LSB = 3;
   localparam logic [2:0] CODE_OFF = 3'h4;
   localparam logic [2:0] CODE_LOWPWR = 3'h5;
   localparam logic [2:0] CODE_ACTIVE = 3'h6;
   localparam logic [2:0] CODE_ACTIVE_ALT = 3'h7;
   localparam logic [7:0] WRITE_MASK = 8'h3F;

   typedef enum logic [1:0] {
      RLC_OFF,
      RLC_LOWPWR,
      RLC_ACTIVE
   } rlc_mode_t;

   typedef struct packed {
      logic [1:0] reserved;
      logic [2:0] exit_state_field;
      logic [2:0] live_state_field;
   } rlc_ctrl_t;

   typedef struct packed {
      logic enable;
      logic low_power;
      logic discharge;
   } rlc_drive_t;
endpackage

// ===== hdl/rlc_ref_ldo_ctrl.sv
/*
 holds the reference regulator control register and its sibling's, and drives both regulators and the combo supply.
 assumes register access strobes from the spi register file on mclk; standby exit pin is asynchronous.
*/
`timescale 1ns/1ps
module rlc_ref_ldo_ctrl (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   input wire logic standby_exit_pin,
   input wire logic combo_card_supply_sel_3v3,
   output rlc_pkg::rlc_drive_t ref_ldo_drive,
   output rlc_pkg::rlc_drive_t sibling_ldo_drive,
   output logic combo_card_supply_ldo_mode,
   output logic combo_card_supply_switch_mode
);
   rlc_pkg::rlc_ctrl_t ref_ctrl_ff;
   rlc_pkg::rlc_ctrl_t sib_ctrl_ff;
   logic [2:0] exit_sync_ff;
   logic exit_seen_ff;
   logic exit_rise;

   function automatic rlc_pkg::rlc_mode_t decode_mode(input logic [2:0] code);
      case (code)
         rlc_pkg::CODE_LOWPWR: decode_mode = rlc_pkg::RLC_LOWPWR;
         rlc_pkg::CODE_ACTIVE, rlc_pkg::CODE_ACTIVE_ALT: decode_mode = rlc_pkg::RLC_ACTIVE;
         default: decode_mode = rlc_pkg::RLC_OFF;
      endcase
   endfunction

   function automatic rlc_pkg::rlc_drive_t drive_of(input logic [2:0] code);
      rlc_pkg::rlc_mode_t m;
      m = decode_mode(code);
      drive_of.enable = (m != rlc_pkg::RLC_OFF);
      drive_of.low_power = (m == rlc_pkg::RLC_LOWPWR);
      drive_of.discharge = (m == rlc_pkg::RLC_OFF);
   endfunction

   function automatic logic exit_copies(input logic [2:0] code);
      exit_copies = code[2];
   endfunction

   // standby exit pin: three stages, change counts when stages two and three agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         exit_sync_ff <= 3'h0;
      end else begin
         exit_sync_ff <= {exit_sync_ff[1:0], standby_exit_pin};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         exit_seen_ff <= 1'b0;
      end else if (exit_sync_ff[1] == exit_sync_ff[2]) begin
         exit_seen_ff <= exit_sync_ff[2];
      end
   end

   assign exit_rise = (exit_sync_ff[1] == exit_sync_ff[2]) && exit_sync_ff[2] && !exit_seen_ff;

   // spi write first, then standby exit copy wins in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_ctrl_ff <= rlc_pkg::REF_LDO_CTRL_RST;
      end else begin
         if (reg_wr && reg_addr == rlc_pkg::REF_LDO_CTRL_ADDR) begin
            ref_ctrl_ff <= reg_wdata & rlc_pkg::WRITE_MASK;
         end
         if (exit_rise && exit_copies(ref_ctrl_ff.exit_state_field)) begin
            ref_ctrl_ff.live_state_field <= ref_ctrl_ff.exit_state_field;
            if (reg_wr && reg_addr == rlc_pkg::REF_LDO_CTRL_ADDR) begin
               ref_ctrl_ff.exit_state_field <= reg_wdata[rlc_pkg::EXIT_LSB +: 3];
               ref_ctrl_ff.reserved <= 2'h0;
            end
         end
      end
   end

   // sibling has its own register and its own copy on exit
   always_ff @(posedge mclk) begin
      if (rst) begin
         sib_ctrl_ff <= rlc_pkg::SIBLING_CTRL_RST;
      end else begin
         if (reg_wr && reg_addr == rlc_pkg::SIBLING_CTRL_ADDR) begin
            sib_ctrl_ff <= reg_wdata & rlc_pkg::WRITE_MASK;
         end
         if (exit_rise && exit_copies(sib_ctrl_ff.exit_state_field)) begin
            sib_ctrl_ff.live_state_field <= sib_ctrl_ff.exit_state_field;
            if (reg_wr && reg_addr == rlc_pkg::SIBLING_CTRL_ADDR) begin
               sib_ctrl_ff.exit_state_field <= reg_wdata[rlc_pkg::EXIT_LSB +: 3];
               sib_ctrl_ff.reserved <= 2'h0;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         reg_hit <= reg_rd && (reg_addr == rlc_pkg::REF_LDO_CTRL_ADDR || reg_addr == rlc_pkg::SIBLING_CTRL_ADDR);
         if (reg_rd && reg_addr == rlc_pkg::REF_LDO_CTRL_ADDR) begin
            reg_rdata <= ref_ctrl_ff;
         end else if (reg_rd && reg_addr == rlc_pkg::SIBLING_CTRL_ADDR) begin
            reg_rdata <= sib_ctrl_ff;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_ldo_drive <= drive_of(rlc_pkg::CODE_OFF);
         sibling_ldo_drive <= drive_of(rlc_pkg::CODE_OFF);
         combo_card_supply_ldo_mode <= 1'b1;
         combo_card_supply_switch_mode <= 1'b0;
      end else begin
         ref_ldo_drive <= drive_of(ref_ctrl_ff.live_state_field);
         sibling_ldo_drive <= drive_of(sib_ctrl_ff.live_state_field);
         combo_card_supply_ldo_mode <= !combo_card_supply_sel_3v3;
         combo_card_supply_switch_mode <= combo_card_supply_sel_3v3;
      end
   end
endmodule

// ===== sim/ldo_state_control_reg_tb_top.sv
/* bench top; needs the package, checker and controller model */
`timescale 1ns/1ps
module ldo_state_control_reg_tb_top;
   logic mclk = 1'b0, rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, reg_hit, standby_exit_pin, combo_card_supply_sel_3v3;
   logic combo_card_supply_ldo_mode, combo_card_supply_switch_mode;
   rlc_pkg::rlc_drive_t ref_ldo_drive, sibling_ldo_drive;
   int n_mismatch = 0, n_tests = 0;
   rlc_ref_ldo_ctrl rlc_ref_ldo_ctrl_i (.*);
   rlc_m rlc_m_i (.*);
   initial forever #25 mclk = ~mclk;
   task automatic chk(input logic [7:0] g, e);
      n_tests++;
      if (g !== e) n_mismatch++;
      if (g !== e) $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
   endtask
   task automatic rd(input logic [7:0] a, e);
      rlc_m_i.acc(1'b0, a, 8'h00);
      #1 chk(reg_rdata, e);
      chk({7'h00, reg_hit}, {7'h00, (a == 8'h3F || a == 8'h40)});
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h3F, 8'h24);
      chk({6'h00, combo_card_supply_ldo_mode, combo_card_supply_switch_mode}, 8'h02);
      for (int c = 0; c < 8; c++) begin
         rlc_m_i.acc(1'b1, 8'h3F, {5'h1C, c[2:0]});
         rd(8'h3F, {5'h04, c[2:0]});
         chk({5'h00, ref_ldo_drive}, c == 5 ? 8'h06 : c > 5 ? 8'h04 : 8'h01);
      end
      chk({5'h00, sibling_ldo_drive}, 8'h01);
      rd(8'h40, 8'h3C);
      for (int e = 0; e < 8; e++) begin
         rlc_m_i.acc(1'b1, 8'h3F, {2'b00, e[2:0], 3'h6});
         rlc_m_i.ex(e == 7);
         rd(8'h3F, {2'b00, e[2:0], e[2] ? e[2:0] : 3'h6});
      end
      chk({6'h00, combo_card_supply_ldo_mode, combo_card_supply_switch_mode}, 8'h01);
      rd(8'h41, 8'h00);
      rd(8'h40, 8'h3F);
      chk({5'h00, sibling_ldo_drive}, 8'h04);
      finish_test();
   end
endmodule

// ===== sim/rlc_assertions.sv
/* port checks of rlc_ref_ldo_ctrl; bound in below */
`timescale 1ns/1ps
module rlc_chk (
   input wire logic mclk, rst, reg_wr, reg_rd, reg_hit, standby_exit_pin,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   input wire rlc_pkg::rlc_drive_t ref_ldo_drive
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire w = reg_wr && reg_addr == 8'h3F && !standby_exit_pin;
   wire r = reg_rd && reg_addr == 8'h3F;
   sequence wr_rd;
      w ##2 r;
   endsequence
   a_read_hit: assert property (r |=> reg_hit) else $error("hit");
   a_bad_addr: assert property (reg_rd && reg_addr > 8'h40 |=> !reg_rdata) else $error("unmapped");
   a_top_zero: assert property (reg_hit |-> !reg_rdata[7:6]) else $error("top");
   a_exit_kept: assert property (wr_rd |=> reg_rdata[5:3] == $past(reg_wdata[5:3], 3)) else $error("exit");
   a_off_drain: assert property (ref_ldo_drive.discharge != ref_ldo_drive.enable) else $error("drain");
   a_low_power: assert property (w && reg_wdata[2:0] == 3'h5 |-> ##2 ref_ldo_drive == 3'b110) else $error("lp");
   a_hit_cause: assert property (reg_hit |-> $past(reg_rd)) else $error("cause");
   a_idle_zero: assert property (!reg_rd |=> !reg_rdata) else $error("idle");
endmodule
bind rlc_ref_ldo_ctrl rlc_chk rlc_chk_i (.*);

// ===== sim/rlc_m.sv
/* controller model: register strobes, exit pin, supply select; runs on mclk */
`timescale 1ns/1ps
module rlc_m (
   input wire logic mclk,
   output logic [7:0] reg_addr, reg_wdata,
   output logic reg_wr, reg_rd, standby_exit_pin, combo_card_supply_sel_3v3
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd, standby_exit_pin, combo_card_supply_sel_3v3} = '0;
   // released address and data lines show the inverse of their last value; both strobes drop to 0
   task automatic acc(input logic w, input logic [7:0] a, d);
      @(posedge mclk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge mclk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
   endtask
   task automatic ex(input logic s);
      @(posedge mclk);
      {standby_exit_pin, combo_card_supply_sel_3v3} <= {1'b1, s};
      repeat (6) @(posedge mclk);
      standby_exit_pin <= 1'b0;
   endtask
endmodule
